// *** logic/gpss_pkg.sv ***
// Purpose: constants for the call gate privilege and stack switch checker
// Assumes: 32-bit descriptor tables and task state block layout
// Notes: register map is word aligned on AHB-Lite
`default_nettype none
package gpss_pkg;
	// ==========================================
	// Register map
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_STAT  = 8'h04;
	localparam logic [7:0] A_FSEL  = 8'h08;
	localparam logic [7:0] A_FOFF  = 8'h0C;
	localparam logic [7:0] A_TBASE = 8'h10;
	localparam logic [7:0] A_TSS   = 8'h14;
	localparam logic [7:0] A_CPL   = 8'h18;
	localparam logic [7:0] A_SS    = 8'h1C;
	localparam logic [7:0] A_ESP   = 8'h20;
	localparam logic [7:0] A_CS    = 8'h24;
	localparam logic [7:0] A_EIP   = 8'h28;
	localparam logic [7:0] A_SBASE = 8'h2C;
	localparam logic [7:0] A_ENTRY = 8'h30;
	// ==========================================
	// Field positions
	localparam int CTRL_START = 0;
	localparam int CTRL_CALL  = 1;
	localparam int F_DONE     = 0;
	localparam int F_GP       = 1;
	localparam int F_TS       = 2;
	localparam int F_NP       = 3;
	localparam int F_SW       = 4;
	localparam int D_WR       = 9;
	localparam int D_CONF     = 10;
	localparam int D_CODE     = 11;
	localparam int D_S        = 12;
	localparam int D_DPL      = 13;
	localparam int D_P        = 15;
	localparam logic [2:0] GATE_TYPE = 3'h4;
	// ==========================================
	// Reset values and offsets
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam logic [1:0]  RST_CPL  = 2'h0;
	localparam logic [31:0] TSS_ESP0 = 32'h0000_0004;
	localparam logic [31:0] TSS_SS0  = 32'h0000_0008;
	localparam logic [15:0] SEL_MASK = 16'hFFF8;
	localparam logic [31:0] HI_WORD  = 32'h0000_0004;
	localparam logic [31:0] SZ_WORD  = 32'h0000_0002;
	localparam logic [31:0] SZ_DWORD = 32'h0000_0004;
	// ==========================================
	// Sequencer states
	typedef enum logic [4:0] {
		S_IDLE, S_RD_G0, S_RD_G1, S_CHKG, S_RD_C0, S_RD_C1, S_CHKC,
		S_RD_TE, S_RD_TS, S_RD_S0, S_RD_S1, S_CHKS, S_PUSH_SS,
		S_PUSH_ESP, S_RD_P, S_WR_P, S_PUSH_CS, S_PUSH_EIP, S_FINISH
	} gpss_state_t;
endpackage
`default_nettype wire

// *** logic/gpss_top.sv ***
// Purpose: far call and jump through a call gate, with stack switch
// Assumes: memory port answers each request with one mem_ack pulse
// Notes: mem_err with mem_ack flags a limit violation on that access
// How it works
// - Far pointer offset is stored nowhere; only its selector is used.
// - Entry address is code descriptor base plus gate offset.
// - Current level must not exceed gate level.
// - Selector requester level must not exceed gate level.
// - Call to nonconforming code needs destination level at most current.
// - Jump to nonconforming code needs destination level equal current.
// - Conforming destination needs destination level at most current.
// - Call inward to nonconforming code takes new level and switches stack.
// - Conforming destination keeps level and stack.
// - Stack pointers in task state block are only ever read.
// - No inward transfer to level 3, so no level 3 stack fetch.
// - Destination level indexes the new stack pair in task state block.
// - Limit fault reading new stack pair or descriptor raises task fault.
// - Bad stack descriptor privilege or type raises task fault.
// - Hold caller stack, load new pair, push old selector then pointer.
// - Copy gate parameter count items; zero copies none.
// - Then push return code selector and return pointer.
// - Finally load code selector and pointer from the gate.
// - Parameter count holds up to 31 items.
// - Items are words for 16-bit gates, doublewords for 32-bit gates.
// - Gate with valid flag clear raises not present fault.
`timescale 1ns/1ns
`default_nettype none
module gpss_top
	import gpss_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	output logic             mem_req,
	output logic             mem_we,
	output logic             mem_wide,
	output logic [31:0]      mem_addr,
	output logic [31:0]      mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic        mem_err,
	input  wire logic [31:0] mem_rdata
);
	// ==========================================
	// State
	typedef struct packed {
		gpss_state_t st;
		logic        is_call;
		logic [15:0] fsel;
		logic [31:0] tbase;
		logic [31:0] task_state_block;
		logic [1:0]  current_priv_level;
		logic [15:0] ss;
		logic [31:0] stack_pointer_reg;
		logic [15:0] cs;
		logic [31:0] instr_pointer_reg;
		logic [31:0] sbase;
		logic [31:0] entry;
		logic [4:0]  flg;
		logic [31:0] gw0;
		logic [31:0] gw1;
		logic [31:0] cw0;
		logic [31:0] cw1;
		logic [31:0] sw0;
		logic [31:0] sw1;
		logic [31:0] nesp;
		logic [15:0] nss;
		logic [15:0] oss;
		logic [31:0] oesp;
		logic [31:0] obase;
		logic [31:0] pdat;
		logic [4:0]  k;
		logic        ad_wr;
		logic        ad_rd;
		logic [7:0]  ad_idx;
		logic        hready;
		logic [31:0] hrdata;
		logic        hresp;
		logic        req;
		logic        we;
		logic        wide;
		logic [31:0] addr;
		logic [31:0] wdata;
	} gpss_regs_t;

	gpss_regs_t r_reg;
	gpss_regs_t r_next;

	// ==========================================
	// Decoded descriptor fields
	logic [1:0]  gdpl;
	logic        g_is_gate;
	logic        g_priv_ok;
	logic        g32;
	logic [15:0] gsel;
	logic [31:0] goff;
	logic [1:0]  ddpl;
	logic        dconf;
	logic        dcode;
	logic        d_priv_ok;
	logic        do_sw;
	logic        stk_ok;
	logic [31:0] sz;
	logic        busy;
	logic        mdone;

	assign gdpl      = r_reg.gw1[D_DPL+1:D_DPL];
	assign g_is_gate = !r_reg.gw1[D_S] && r_reg.gw1[10:8] == GATE_TYPE;
	assign g_priv_ok = r_reg.current_priv_level <= gdpl && r_reg.fsel[1:0] <= gdpl;
	assign g32       = r_reg.gw1[D_CODE];
	assign gsel      = r_reg.gw0[31:16];
	assign goff      = g32 ? {r_reg.gw1[31:16], r_reg.gw0[15:0]} : {16'h0000, r_reg.gw0[15:0]};
	assign ddpl      = r_reg.cw1[D_DPL+1:D_DPL];
	assign dconf     = r_reg.cw1[D_CONF];
	assign dcode     = r_reg.cw1[D_S] && r_reg.cw1[D_CODE];
	// Jumps into nonconforming code may not change level
	assign d_priv_ok = (r_reg.is_call || dconf) ? ddpl <= r_reg.current_priv_level : ddpl == r_reg.current_priv_level;
	assign do_sw     = r_reg.is_call && !dconf && ddpl < r_reg.current_priv_level;
	assign stk_ok    = r_reg.sw1[D_S] && !r_reg.sw1[D_CODE] && r_reg.sw1[D_WR]
		&& r_reg.sw1[D_DPL+1:D_DPL] == ddpl && r_reg.nss[1:0] == ddpl && r_reg.sw1[D_P];
	assign sz        = g32 ? SZ_DWORD : SZ_WORD;
	assign busy      = r_reg.st != S_IDLE;
	assign mdone     = r_reg.req && mem_ack;

	function automatic logic [31:0] rd_word(input gpss_regs_t s, input logic b, input logic [7:0] a);
		logic [31:0] v;
		v = RST_WORD;
		case (a)
			A_CTRL:  v = {30'h0, s.is_call, 1'b0};
			A_STAT:  v = {26'h0, s.flg, b};
			A_FSEL:  v = {16'h0000, s.fsel};
			A_TBASE: v = s.tbase;
			A_TSS:   v = s.task_state_block;
			A_CPL:   v = {30'h0, s.current_priv_level};
			A_SS:    v = {16'h0000, s.ss};
			A_ESP:   v = s.stack_pointer_reg;
			A_CS:    v = {16'h0000, s.cs};
			A_EIP:   v = s.instr_pointer_reg;
			A_SBASE: v = s.sbase;
			A_ENTRY: v = s.entry;
			default: v = RST_WORD;
		endcase
		return v;
	endfunction

	// ==========================================
	// Next state
	always_comb begin
		logic [31:0] maddr;
		logic [31:0] mwd;
		logic        mwe;
		logic        mst;
		logic [31:0] poff;
		r_next = r_reg;
		maddr  = RST_WORD;
		mwd    = RST_WORD;
		mwe    = 1'b0;
		mst    = 1'b1;
		poff   = ({27'h0, r_reg.k} - 32'd1) << (g32 ? 2 : 1);
		// Bus slave: reads take one wait state so a write just ahead is seen
		if (r_reg.ad_rd) begin
			r_next.hrdata = rd_word(r_reg, busy, r_reg.ad_idx);
			r_next.hready = 1'b1;
			r_next.ad_rd  = 1'b0;
		end
		if (r_reg.ad_wr) begin
			r_next.ad_wr = 1'b0;
			if (!busy) begin
				case (r_reg.ad_idx)
					A_CTRL: begin
						r_next.is_call = hwdata[CTRL_CALL];
						if (hwdata[CTRL_START]) begin
							r_next.flg = 5'h00;
							r_next.st  = S_RD_G0;
						end
					end
					A_FSEL:  r_next.fsel = hwdata[15:0];
					A_FOFF:  r_next.fsel = r_reg.fsel;
					A_TBASE: r_next.tbase = hwdata;
					A_TSS:   r_next.task_state_block = hwdata;
					A_CPL:   r_next.current_priv_level = hwdata[1:0];
					A_SS:    r_next.ss = hwdata[15:0];
					A_ESP:   r_next.stack_pointer_reg = hwdata;
					A_CS:    r_next.cs = hwdata[15:0];
					A_EIP:   r_next.instr_pointer_reg = hwdata;
					A_SBASE: r_next.sbase = hwdata;
					default: r_next.ad_wr = 1'b0;
				endcase
			end
		end
		if (hsel && htrans[1] && hready) begin
			r_next.ad_idx = {haddr[7:2], 2'b00};
			r_next.ad_wr  = hwrite;
			r_next.ad_rd  = !hwrite;
			r_next.hready = hwrite;
		end
		// Memory address and data per state
		case (r_reg.st)
			S_RD_G0:    maddr = r_reg.tbase + {16'h0000, r_reg.fsel & SEL_MASK};
			S_RD_G1:    maddr = r_reg.tbase + {16'h0000, r_reg.fsel & SEL_MASK} + HI_WORD;
			S_RD_C0:    maddr = r_reg.tbase + {16'h0000, gsel & SEL_MASK};
			S_RD_C1:    maddr = r_reg.tbase + {16'h0000, gsel & SEL_MASK} + HI_WORD;
			S_RD_TE:    maddr = r_reg.task_state_block + TSS_ESP0 + {27'h0, ddpl, 3'b000};
			S_RD_TS:    maddr = r_reg.task_state_block + TSS_SS0 + {27'h0, ddpl, 3'b000};
			S_RD_S0:    maddr = r_reg.tbase + {16'h0000, r_reg.nss & SEL_MASK};
			S_RD_S1:    maddr = r_reg.tbase + {16'h0000, r_reg.nss & SEL_MASK} + HI_WORD;
			S_RD_P:     maddr = r_reg.obase + r_reg.oesp + poff;
			S_PUSH_SS:  mwd = {16'h0000, r_reg.oss};
			S_PUSH_ESP: mwd = r_reg.oesp;
			S_WR_P:     mwd = r_reg.pdat;
			S_PUSH_CS:  mwd = {16'h0000, r_reg.cs};
			S_PUSH_EIP: mwd = r_reg.instr_pointer_reg;
			default:    mst = 1'b0;
		endcase
		// Only stack slots are ever written, never the task state block
		case (r_reg.st)
			S_PUSH_SS, S_PUSH_ESP, S_WR_P, S_PUSH_CS, S_PUSH_EIP: begin
				mwe   = 1'b1;
				maddr = r_reg.sbase + r_reg.stack_pointer_reg - sz;
			end
			default: mwe = 1'b0;
		endcase
		if (mst && !r_reg.req) begin
			r_next.req   = 1'b1;
			r_next.we    = mwe;
			r_next.wide  = g32;
			r_next.addr  = maddr;
			r_next.wdata = mwd;
		end
		if (mdone) begin
			r_next.req = 1'b0;
			r_next.we  = 1'b0;
			if (mwe) begin
				r_next.stack_pointer_reg = r_reg.stack_pointer_reg - sz;
			end
		end
		// ==========================================
		// Transfer sequencer
		case (r_reg.st)
			S_IDLE: r_next.st = r_next.st;
			S_RD_G0, S_RD_G1, S_RD_C0, S_RD_C1: begin
				if (mdone && mem_err) begin
					r_next.flg[F_GP]   = 1'b1;
					r_next.flg[F_DONE] = 1'b1;
					r_next.st          = S_IDLE;
				end else if (mdone) begin
					case (r_reg.st)
						S_RD_G0: r_next.gw0 = mem_rdata;
						S_RD_G1: r_next.gw1 = mem_rdata;
						S_RD_C0: r_next.cw0 = mem_rdata;
						default: r_next.cw1 = mem_rdata;
					endcase
					r_next.st = gpss_state_t'(r_reg.st + 5'd1);
				end
			end
			S_CHKG: begin
				r_next.st = S_RD_C0;
				if (!g_is_gate || !g_priv_ok) begin
					r_next.flg[F_GP]   = 1'b1;
					r_next.flg[F_DONE] = 1'b1;
					r_next.st          = S_IDLE;
				end else if (!r_reg.gw1[D_P]) begin
					r_next.flg[F_NP]   = 1'b1;
					r_next.flg[F_DONE] = 1'b1;
					r_next.st          = S_IDLE;
				end
			end
			S_CHKC: begin
				r_next.entry = {r_reg.cw1[31:24], r_reg.cw1[7:0], r_reg.cw0[31:16]} + goff;
				if (!dcode || !d_priv_ok) begin
					r_next.flg[F_GP]   = 1'b1;
					r_next.flg[F_DONE] = 1'b1;
					r_next.st          = S_IDLE;
				end else if (!r_reg.cw1[D_P]) begin
					r_next.flg[F_NP]   = 1'b1;
					r_next.flg[F_DONE] = 1'b1;
					r_next.st          = S_IDLE;
				end else if (do_sw) begin
					r_next.st = S_RD_TE;
				end else if (r_reg.is_call) begin
					r_next.st = S_PUSH_CS;
				end else begin
					r_next.st = S_FINISH;
				end
			end
			S_RD_TE, S_RD_TS, S_RD_S0, S_RD_S1: begin
				if (mdone && mem_err) begin
					r_next.flg[F_TS]   = 1'b1;
					r_next.flg[F_DONE] = 1'b1;
					r_next.st          = S_IDLE;
				end else if (mdone) begin
					case (r_reg.st)
						S_RD_TE: r_next.nesp = mem_rdata;
						S_RD_TS: r_next.nss = mem_rdata[15:0];
						S_RD_S0: r_next.sw0 = mem_rdata;
						default: r_next.sw1 = mem_rdata;
					endcase
					r_next.st = gpss_state_t'(r_reg.st + 5'd1);
				end
			end
			S_CHKS: begin
				if (!stk_ok) begin
					r_next.flg[F_TS]   = 1'b1;
					r_next.flg[F_DONE] = 1'b1;
					r_next.st          = S_IDLE;
				end else begin
					r_next.oss   = r_reg.ss;
					r_next.oesp  = r_reg.stack_pointer_reg;
					r_next.obase = r_reg.sbase;
					r_next.ss    = r_reg.nss;
					r_next.stack_pointer_reg   = r_reg.nesp;
					r_next.sbase = {r_reg.sw1[31:24], r_reg.sw1[7:0], r_reg.sw0[31:16]};
					r_next.k     = r_reg.gw1[4:0];
					r_next.flg[F_SW] = 1'b1;
					r_next.st    = S_PUSH_SS;
				end
			end
			S_PUSH_SS: begin
				if (mdone) begin
					r_next.st = S_PUSH_ESP;
				end
			end
			S_PUSH_ESP, S_WR_P: begin
				// Parameters go deepest first so the caller's layout is kept
				if (mdone) begin
					r_next.k  = (r_reg.st == S_WR_P) ? r_reg.k - 5'd1 : r_reg.k;
					r_next.st = (r_next.k != 5'd0) ? S_RD_P : S_PUSH_CS;
				end
			end
			S_RD_P: begin
				if (mdone) begin
					r_next.pdat = mem_rdata;
					r_next.st   = S_WR_P;
				end
			end
			S_PUSH_CS: begin
				if (mdone) begin
					r_next.st = S_PUSH_EIP;
				end
			end
			S_PUSH_EIP: begin
				if (mdone) begin
					r_next.st = S_FINISH;
				end
			end
			S_FINISH: begin
				r_next.current_priv_level = r_reg.flg[F_SW] ? ddpl : r_reg.current_priv_level;
				r_next.cs  = {gsel[15:2], r_next.current_priv_level};
				r_next.instr_pointer_reg = goff;
				r_next.flg[F_DONE] = 1'b1;
				r_next.st  = S_IDLE;
			end
			default: r_next.st = S_IDLE;
		endcase
		r_next.hresp = 1'b0;
	end

	// ==========================================
	// Registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg        <= '0;
			r_reg.st     <= S_IDLE;
			r_reg.current_priv_level    <= RST_CPL;
			r_reg.ss     <= RST_HALF;
			r_reg.stack_pointer_reg    <= RST_WORD;
			r_reg.hready <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign hreadyout = r_reg.hready;
	assign hrdata    = r_reg.hrdata;
	assign hresp     = r_reg.hresp;
	assign mem_req   = r_reg.req;
	assign mem_we    = r_reg.we;
	assign mem_wide  = r_reg.wide;
	assign mem_addr  = r_reg.addr;
	assign mem_wdata = r_reg.wdata;

	// ==========================================
	// Assertions
	sequence s_enter_push;
		r_reg.st == S_CHKS && stk_ok;
	endsequence
	sequence s_ss_first;
		r_reg.st == S_PUSH_SS ##1 (r_reg.req && r_reg.we && r_reg.wdata[15:0] == r_reg.oss);
	endsequence

	property p_gate_priv;
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.st == S_CHKG && !g_priv_ok) |=> (r_reg.st == S_IDLE && r_reg.flg[F_GP]);
	endproperty
	a_gate_priv: assert property (p_gate_priv) else $error("gate privilege not refused");

	property p_rpl;
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.st == S_CHKG && r_reg.fsel[1:0] > gdpl) |=> r_reg.flg[F_GP];
	endproperty
	a_rpl: assert property (p_rpl) else $error("requester level not refused");

	property p_np;
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.st == S_CHKG && g_is_gate && g_priv_ok && !r_reg.gw1[D_P])
		|=> (r_reg.flg[F_NP] && r_reg.st == S_IDLE);
	endproperty
	a_np: assert property (p_np) else $error("absent gate not faulted");

	property p_jmp_eq;
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.st == S_CHKC && dcode && !r_reg.is_call && !dconf && ddpl != r_reg.current_priv_level)
		|=> r_reg.flg[F_GP];
	endproperty
	a_jmp_eq: assert property (p_jmp_eq) else $error("jump level mismatch accepted");

	property p_dest_le;
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.st == S_CHKC && dcode && (r_reg.is_call || dconf) && ddpl > r_reg.current_priv_level)
		|=> r_reg.flg[F_GP];
	endproperty
	a_dest_le: assert property (p_dest_le) else $error("outward call accepted");

	property p_switch;
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.st == S_CHKC && dcode && d_priv_ok && r_reg.cw1[D_P] && do_sw)
		|=> r_reg.st == S_RD_TE ##1 (r_reg.req && r_reg.addr == r_reg.task_state_block + TSS_ESP0 + {27'h0, ddpl, 3'b000});
	endproperty
	a_switch: assert property (p_switch) else $error("stack switch fetch wrong");

	property p_conf_keep;
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.st == S_CHKC && dconf) |=> (r_reg.st != S_RD_TE);
	endproperty
	a_conf_keep: assert property (p_conf_keep) else $error("conforming target switched");

	property p_conf_level;
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.st == S_FINISH && dconf) |=> $stable(r_reg.current_priv_level);
	endproperty
	a_conf_level: assert property (p_conf_level) else $error("conforming target changed level");

	property p_new_level;
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.st == S_FINISH && r_reg.flg[F_SW])
		|=> (r_reg.current_priv_level == $past(ddpl) && r_reg.cs[1:0] == $past(ddpl));
	endproperty
	a_new_level: assert property (p_new_level) else $error("new level not taken");

	property p_tss_ro;
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.st inside {S_RD_TE, S_RD_TS, S_RD_S0, S_RD_S1} && r_reg.req) |-> !r_reg.we;
	endproperty
	a_tss_ro: assert property (p_tss_ro) else $error("write during stack fetch");

	property p_ts_limit;
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.st inside {S_RD_TE, S_RD_TS, S_RD_S0, S_RD_S1} && mdone && mem_err)
		|=> (r_reg.flg[F_TS] && r_reg.st == S_IDLE);
	endproperty
	a_ts_limit: assert property (p_ts_limit) else $error("limit fault not raised");

	property p_save_order;
		@(posedge hclk) disable iff (!hresetn)
		s_enter_push |=> s_ss_first;
	endproperty
	a_save_order: assert property (p_save_order) else $error("old stack not pushed first");

	property p_fault_keep;
		@(posedge hclk) disable iff (!hresetn)
		(r_reg.st == S_CHKG && !g_priv_ok) |=> ($stable(r_reg.current_priv_level) && $stable(r_reg.stack_pointer_reg) && $stable(r_reg.cs));
	endproperty
	a_fault_keep: assert property (p_fault_keep) else $error("fault changed state");
endmodule
`default_nettype wire

// *** test/gpss_mem_model.sv ***
// Purpose: memory behind the gate checker: tables, task state block, stacks
// Assumes: byte addressed, little endian, one ack pulse per request
// Notes: latency and one faulting address are chosen by the bench
`timescale 1ns/1ns
`default_nettype none
module gpss_mem_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic        wide,
	input  wire logic [31:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic [31:0] err_addr,
	input  wire logic [1:0]  lat,
	output logic             ack,
	output logic             err,
	output logic [31:0]      rdata
);
	logic [7:0] mem [int unsigned];
	int         cnt;
	// Unwritten bytes read as a fixed pattern, never as zero
	function automatic logic [7:0] rb(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : 8'hA5;
	endfunction
	function automatic logic [31:0] get(input logic [31:0] a);
		return {rb(a + 3), rb(a + 2), rb(a + 1), rb(a)};
	endfunction
	task automatic put(input logic [31:0] a, input logic [31:0] d);
		for (int i = 0; i < 4; i++)
			mem[a + i] = d[8 * i +: 8];
	endtask
	// ==========================================
	// Request handling
	// Idle data lines toggle so a stale sample cannot match by luck
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack   <= 1'b0;
			err   <= 1'b0;
			rdata <= 32'h0000_0000;
			cnt   <= 0;
		end else if (req && !ack && cnt >= lat) begin
			ack   <= 1'b1;
			err   <= addr == err_addr;
			rdata <= get(addr);
			cnt   <= 0;
			if (we)
				for (int i = 0; i < (wide ? 4 : 2); i++)
					mem[addr + i] = wdata[8 * i +: 8];
		end else begin
			ack   <= 1'b0;
			err   <= 1'b0;
			rdata <= ~rdata;
			cnt   <= req ? cnt + 1 : 0;
		end
	end
endmodule
`default_nettype wire

// *** test/tb_gate_privilege_stack_switch.sv ***
// Purpose: self-checking bench for the call gate checker
// Assumes: single AHB-Lite master, memory model on the far side
// Notes: fixed corner cases, then random cases from a fixed seed
`timescale 1ns/1ns
`default_nettype none
module tb_gate_privilege_stack_switch
	import gpss_pkg::*;
;
	localparam logic [31:0] TBL  = 32'h0000_1000;
	localparam logic [31:0] TSB  = 32'h0000_2000;
	localparam logic [31:0] SB   = 32'h0000_8000;
	localparam logic [31:0] NB   = 32'h0001_0000;
	localparam logic [31:0] CB   = 32'h5A40_3000;
	localparam logic [31:0] OSP  = 32'h0000_0100;
	localparam logic [31:0] NSP  = 32'h0000_0200;
	localparam logic [31:0] OSS  = 32'h0000_003B;
	localparam logic [31:0] OCS  = 32'h0000_004B;
	localparam logic [31:0] OEIP = 32'h1357_9BDF;
	localparam logic [7:0]  RA [10] = '{A_FSEL, A_FOFF, A_TBASE, A_TSS, A_CPL,
		A_SS, A_ESP, A_CS, A_EIP, A_SBASE};
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        mem_req, mem_we, mem_wide, mem_ack, mem_err;
	logic [1:0]  htrans, lat;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata;
	logic [31:0] err_addr, seed, q;
	int          num_errors, checks;

	gpss_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.mem_req(mem_req), .mem_we(mem_we), .mem_wide(mem_wide), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err),
		.mem_rdata(mem_rdata));
	gpss_mem_model mem_i (.clk(hclk), .rst_n(hresetn), .req(mem_req), .we(mem_we),
		.wide(mem_wide), .addr(mem_addr), .wdata(mem_wdata), .err_addr(err_addr),
		.lat(lat), .ack(mem_ack), .err(mem_err), .rdata(mem_rdata));

	// ==========================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hwait();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			tally_and_finish();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		hwait();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic dput(input logic [31:0] a, input logic [31:0] b, input logic p,
		input logic [1:0] d, input logic [3:0] t);
		mem_i.put(a, {b[15:0], 16'hFFFF});
		mem_i.put(a + 4, {b[31:24], 8'hCF, p, d, 1'b1, t, b[23:16]});
	endtask

	// ==========================================
	// One gate transfer: set up, start, compare
	task automatic run(input logic c, input logic f, input logic [1:0] current_priv_level,
		input logic [1:0] requester_priv_level, input logic [1:0] gd, input logic [1:0] cd,
		input logic gp, input logic cp, input logic [4:0] k, input logic big,
		input int tsf);
		logic [31:0] sz, ofs, b, e, mk, go;
		logic [31:0] rv [10];
		logic [1:0]  ex, lv;
		logic        sw;
		int          n, j, np;
		sz  = big ? 32'h4 : 32'h2;
		ofs = rnd();
		// A 16-bit gate carries only the low half of the entry offset
		go  = big ? ofs : {16'h0000, ofs[15:0]};
		ex  = 2'h0;
		if (current_priv_level > gd || requester_priv_level > gd)
			ex = 2'h1;
		else if (!gp)
			ex = 2'h2;
		else if (tsf == 3)
			ex = 2'h1;
		else if (f || c ? cd > current_priv_level : cd != current_priv_level)
			ex = 2'h1;
		else if (!cp)
			ex = 2'h2;
		sw = ex == 2'h0 && c && !f && cd < current_priv_level;
		if (sw && tsf != 0)
			ex = 2'h3;
		sw = sw && ex == 2'h0;
		lv = sw ? cd : current_priv_level;
		np = sw ? 4 + k : (ex == 2'h0 && c ? 2 : 0);
		mem_i.put(TBL + 16, {16'h0018, ofs[15:0]});
		mem_i.put(TBL + 20, {ofs[31:16], gp, gd, 1'b0, big, GATE_TYPE, 3'h0, k});
		dput(TBL + 24, CB, cp, cd, {1'b1, f, 2'h2});
		dput(TBL + 32, NB, 1'b1, tsf == 2 ? ~cd : cd, 4'h2);
		mem_i.put(TSB + 4 + 8 * cd, NSP);
		mem_i.put(TSB + 8 + 8 * cd, 32'h20 | cd);
		for (n = 0; n < 32; n++)
			mem_i.put(SB + OSP + 4 * n, rnd());
		err_addr <= tsf == 1 ? TSB + 4 + 8 * cd : tsf == 3 ? TBL + 24 : 32'hFFFF_FFF0;
		lat      <= ofs[1:0];
		rv = '{32'h10 | requester_priv_level, rnd(), TBL, TSB, {30'h0, current_priv_level}, OSS, OSP, OCS, OEIP, SB};
		for (n = 0; n < 10; n++)
			wr(RA[n], rv[n]);
		rchk(A_FOFF, 32'h0);
		wr(A_CTRL, {30'h0, c, 1'b1});
		n = 0;
		do begin
			bus(1'b0, A_STAT, 32'h0, q);
			n++;
		end while (q[0] !== 1'b0 && n < 300);
		chk(q & 32'h3F, {sw, ex == 2'h2, ex == 2'h3, ex == 2'h1, 2'h2});
		if (q[0] !== 1'b0)
			tally_and_finish();
		rchk(A_CPL, {30'h0, lv});
		rchk(A_CS, ex != 2'h0 ? OCS : 32'h18 | lv);
		rchk(A_EIP, ex != 2'h0 ? OEIP : go);
		rchk(A_SS, sw ? 32'h20 | cd : OSS);
		rchk(A_ESP, (sw ? NSP : OSP) - sz * np);
		if (ex == 2'h0)
			rchk(A_ENTRY, CB + go);
		chk(mem_i.get(TSB + 4 + 8 * cd), NSP);
		b = sw ? NB + NSP : SB + OSP;
		for (n = 0; n < np; n++) begin
			j  = sw ? n : n + 2 + k;
			e  = j == 0 ? OSS : j == 1 ? OSP : j == 2 + k ? OCS : j == 3 + k ? OEIP
				: mem_i.get(SB + OSP + (k + 1 - j) * sz);
			mk = j == 0 || j == 2 + k || !big ? 32'hFFFF : 32'hFFFF_FFFF;
			chk(mem_i.get(b - sz * (n + 1)) & mk, e & mk);
		end
		$display("case done call=%0d fault=%0d switch=%0d", c, ex, sw);
	endtask

	// ==========================================
	// Clock, reset and sequence
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	initial begin
		{hresetn, hsel, hwrite, htrans, lat} = '0;
		hsize      = 3'h2;
		haddr      = 32'h0;
		hwdata     = 32'h0;
		err_addr   = 32'hFFFF_FFF0;
		seed       = 32'h0001_31F0;
		num_errors = 0;
		checks     = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		rchk(A_CPL, {30'h0, RST_CPL});
		rchk(8'hFC, 32'h0);
		run(1, 0, 3, 3, 3, 0, 1, 1, 31, 1, 0);
		run(1, 0, 2, 0, 3, 1, 1, 1, 0, 0, 0);
		run(1, 0, 3, 1, 3, 1, 1, 1, 3, 0, 0);
		run(0, 0, 3, 3, 3, 1, 1, 1, 2, 1, 0);
		run(0, 0, 2, 2, 3, 2, 1, 1, 2, 1, 0);
		run(1, 0, 1, 0, 3, 2, 1, 1, 2, 1, 0);
		run(1, 0, 3, 0, 2, 0, 1, 1, 2, 1, 0);
		run(1, 0, 1, 3, 2, 0, 1, 1, 2, 1, 0);
		run(1, 0, 2, 2, 2, 0, 0, 1, 2, 1, 0);
		run(1, 1, 3, 3, 3, 0, 1, 1, 2, 1, 0);
		run(0, 1, 2, 0, 3, 1, 1, 1, 2, 1, 0);
		run(1, 0, 3, 3, 3, 1, 1, 1, 2, 1, 1);
		run(1, 0, 3, 3, 3, 2, 1, 1, 2, 1, 2);
		run(1, 0, 3, 3, 3, 1, 1, 1, 2, 0, 3);
		repeat (30) begin
			q = rnd();
			run(q[0], q[1], q[3:2], q[5:4], q[7:6], q[9:8], q[12:10] != 0,
				q[15:13] != 0, q[20:16], q[21], q[23:22] == 2'h3 ? 1 : 0);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
